// ==== hw/ctr_defs.svh ====
// Register offsets, field positions, reset values and key codes of the top control bank
`ifndef CTR_DEFS_SVH
`define CTR_DEFS_SVH

`define CTR_OFS_CHIP_ID     8'h00
`define CTR_OFS_SOFTWARE_RESET_KEY       8'h01
`define CTR_OFS_LATCH       8'h02
`define CTR_OFS_MASK        8'h03
`define CTR_OFS_LIVE        8'h04

`define CTR_RESET_KEY       8'ha5
`define CTR_SOFTWARE_RESET_KEY_RST       8'h00
`define CTR_LATCH_RST       3'h0
`define CTR_MASK_RST        8'hff
`define CTR_BYTE_ZERO       8'h00
`define CTR_SPARE_ZERO      5'h00

`define CTR_BIT_THERMAL     2
`define CTR_BIT_OVERVOLT    1
`define CTR_BIT_UNDERVOLT   0
`define CTR_NUM_EVENTS      3

`define CTR_BITS_PER_BYTE   4'h8
`define CTR_CNT_ZERO        4'h0
`define CTR_CNT_ONE         4'h1

`endif

// ==== hw/ctr_pkg.sv ====
// Types shared by the top control bank and its bus line detector
package ctr_pkg;

  typedef struct packed {
    logic scl_rise;
    logic scl_fall;
    logic start;
    logic stop;
    logic sda;
  } ctr_line_evt_t;

  typedef enum logic [8:0] {
    CTR_IDLE     = 9'h001,
    CTR_ADDR     = 9'h002,
    CTR_ADDR_ACK = 9'h004,
    CTR_PTR      = 9'h008,
    CTR_PTR_ACK  = 9'h010,
    CTR_WDATA    = 9'h020,
    CTR_WACK     = 9'h040,
    CTR_RDATA    = 9'h080,
    CTR_RACK     = 9'h100
  } ctr_state_t;

endpackage

// ==== hw/ctr_line_detect.sv ====
// Serial bus line watcher: clock edges, start and stop conditions
`timescale 1ns/1ps

module ctr_line_detect (
  // Clock and reset
  input  wire logic              i_clk_sys,
  input  wire logic              i_reset_n,
  // Bus lines
  input  wire logic              i_scl,
  input  wire logic              i_sda,
  // Decoded line events
  output ctr_pkg::ctr_line_evt_t o_evt
);

  logic scl_q;
  logic sda_q;

  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= i_scl;
      sda_q <= i_sda;
    end
  end

  // Data moving while the clock stays high marks start or stop
  assign o_evt.scl_rise = i_scl & ~scl_q;
  assign o_evt.scl_fall = ~i_scl & scl_q;
  assign o_evt.start    = i_scl & scl_q & sda_q & ~i_sda;
  assign o_evt.stop     = i_scl & scl_q & ~sda_q & i_sda;
  assign o_evt.sda      = i_sda;

endmodule // ctr_line_detect

// ==== hw/ctr_top_regs.sv ====
// Top control register bank of the charger behind its serial bus slave
`timescale 1ns/1ps
`include "ctr_defs.svh"

// Contract
// RQ1 - Writing key 0xA5 to the reset register restores all resettable registers.
// RQ2 - The reset register clears itself; reads return its reset value.
// RQ3 - Any other value written there changes nothing and resets nothing.
// RQ4 - Latch bit 2 thermal, bit 1 overvoltage, bit 0 undervolt; spares read zero.
// RQ5 - Reading the latch register returns its bits then clears them all.
// RQ6 - Mask bit one blocks its event from interrupting; masks reset to one.
// RQ7 - Live register shows inverted thermal, overvoltage and undervoltage conditions.
// RQ8 - Each written byte loads at the acknowledge clock rise of that byte.
module ctr_top_regs #(
  parameter logic [6:0] SLAVE_ADDR = 7'h55, // Arbitrary bus address
  parameter logic [7:0] CHIP_ID    = 8'h2b  // Arbitrary identification value
) (
  // Clock and reset
  input  wire logic       i_clk_sys,
  input  wire logic       i_reset_n,
  // Serial bus pins
  input  wire logic       i_scl,
  input  wire logic       i_sda,
  output logic            o_sda,
  output logic            o_sda_oe,
  // Live conditions from the charger
  input  wire logic       i_thermal_shutdown,
  input  wire logic       i_sys_overvolt,
  input  wire logic       i_sys_undervolt,
  // Status toward the charger
  output logic            o_event_pending,
  output logic            o_soft_reset
);

  ctr_pkg::ctr_line_evt_t evt;
  ctr_pkg::ctr_state_t    state_q, state_d;
  logic [3:0]             cnt_q, cnt_d;
  logic [7:0]             sh_q, sh_d;
  logic [7:0]             ptr_q, ptr_d;
  logic                   rw_q, rw_d;
  logic                   oe_q, oe_d;
  logic                   wr_en;
  logic                   rd_load;
  logic [7:0]             mask_q, mask_d;
  logic [2:0]             latch_q, latch_d;
  logic [2:0]             cond_q;
  logic                   pend_q;
  logic                   srst_q;

  ctr_line_detect u_line (
    .i_clk_sys (i_clk_sys),
    .i_reset_n (i_reset_n),
    .i_scl     (i_scl),
    .i_sda     (i_sda),
    .o_evt     (evt)
  );

  // Decode and read selection
  wire [2:0] cond     = {i_thermal_shutdown, i_sys_overvolt, i_sys_undervolt};
  wire [2:0] ev_set   = cond & ~cond_q;
  wire       sel_id   = (ptr_q == `CTR_OFS_CHIP_ID);
  wire       sel_srst = (ptr_q == `CTR_OFS_SOFTWARE_RESET_KEY);
  wire       sel_lat  = (ptr_q == `CTR_OFS_LATCH);
  wire       sel_mask = (ptr_q == `CTR_OFS_MASK);
  wire       sel_live = (ptr_q == `CTR_OFS_LIVE);
  wire       key_hit  = wr_en & sel_srst & (sh_q == `CTR_RESET_KEY); // [RQ1]
  wire       lat_clr  = (rd_load & sel_lat) | key_hit; // [RQ5]
  wire       mask_wr  = wr_en & sel_mask;
  wire [7:0] rd_data  = sel_id   ? CHIP_ID :
                        sel_srst ? `CTR_SOFTWARE_RESET_KEY_RST : // [RQ2]
                        sel_lat  ? {`CTR_SPARE_ZERO, latch_q} : // [RQ4]
                        sel_mask ? mask_q :
                        sel_live ? {`CTR_SPARE_ZERO, ~cond} : // [RQ7]
                        `CTR_BYTE_ZERO;
  wire       got_byte = evt.scl_fall & (cnt_q == `CTR_BITS_PER_BYTE);
  wire       addr_ok  = (sh_q[7:1] == SLAVE_ADDR);

  // Bus slave sequencing
  always_comb begin
    state_d = state_q;
    cnt_d   = cnt_q;
    sh_d    = sh_q;
    ptr_d   = ptr_q;
    rw_d    = rw_q;
    oe_d    = oe_q;
    wr_en   = 1'b0;
    rd_load = 1'b0;
    if (evt.start) begin
      state_d = ctr_pkg::CTR_ADDR;
      cnt_d   = `CTR_CNT_ZERO;
      oe_d    = 1'b0;
    end else if (evt.stop) begin
      state_d = ctr_pkg::CTR_IDLE;
      oe_d    = 1'b0;
    end else begin
      case (state_q)
        ctr_pkg::CTR_ADDR, ctr_pkg::CTR_PTR, ctr_pkg::CTR_WDATA: begin
          if (evt.scl_rise) begin
            sh_d  = {sh_q[6:0], evt.sda};
            cnt_d = cnt_q + `CTR_CNT_ONE;
          end else if (got_byte) begin
            cnt_d = `CTR_CNT_ZERO;
            oe_d  = 1'b1;
            if (state_q == ctr_pkg::CTR_ADDR) begin
              rw_d    = sh_q[0];
              oe_d    = addr_ok;
              state_d = addr_ok ? ctr_pkg::CTR_ADDR_ACK : ctr_pkg::CTR_IDLE;
            end else if (state_q == ctr_pkg::CTR_PTR) begin
              ptr_d   = sh_q;
              state_d = ctr_pkg::CTR_PTR_ACK;
            end else begin
              state_d = ctr_pkg::CTR_WACK;
            end
          end
        end
        ctr_pkg::CTR_ADDR_ACK: begin
          if (evt.scl_fall && rw_q) begin
            rd_load = 1'b1;
            sh_d    = rd_data;
            oe_d    = ~rd_data[7];
            state_d = ctr_pkg::CTR_RDATA;
          end else if (evt.scl_fall) begin
            oe_d    = 1'b0;
            state_d = ctr_pkg::CTR_PTR;
          end
        end
        ctr_pkg::CTR_PTR_ACK: begin
          if (evt.scl_fall) begin
            oe_d    = 1'b0;
            state_d = ctr_pkg::CTR_WDATA;
          end
        end
        ctr_pkg::CTR_WACK: begin
          if (evt.scl_rise) begin
            wr_en = 1'b1; // [RQ8]
          end else if (evt.scl_fall) begin
            oe_d    = 1'b0;
            ptr_d   = ptr_q + 8'h01;
            state_d = ctr_pkg::CTR_WDATA;
          end
        end
        ctr_pkg::CTR_RDATA: begin
          if (evt.scl_rise) begin
            cnt_d = cnt_q + `CTR_CNT_ONE;
          end else if (got_byte) begin
            cnt_d   = `CTR_CNT_ZERO;
            oe_d    = 1'b0;
            ptr_d   = ptr_q + 8'h01;
            state_d = ctr_pkg::CTR_RACK;
          end else if (evt.scl_fall) begin
            sh_d = {sh_q[6:0], 1'b0};
            oe_d = ~sh_q[6];
          end
        end
        ctr_pkg::CTR_RACK: begin
          if (evt.scl_rise && evt.sda) begin
            state_d = ctr_pkg::CTR_IDLE;
          end else if (evt.scl_rise) begin
            cnt_d = `CTR_CNT_ONE;
          end else if (evt.scl_fall && (cnt_q == `CTR_CNT_ONE)) begin
            rd_load = 1'b1;
            cnt_d   = `CTR_CNT_ZERO;
            sh_d    = rd_data;
            oe_d    = ~rd_data[7];
            state_d = ctr_pkg::CTR_RDATA;
          end
        end
        default: begin
          state_d = ctr_pkg::CTR_IDLE;
        end
      endcase
    end
  end

  // Key restores the mask; other writes to the reset register are dropped
  assign mask_d = key_hit ? `CTR_MASK_RST : (mask_wr ? sh_q : mask_q); // [RQ1] [RQ3] [RQ6]

  // Event latches, set wins over clear
  genvar gi;
  generate
    for (gi = 0; gi < `CTR_NUM_EVENTS; gi++) begin : g_latch
      assign latch_d[gi] = ev_set[gi] | (latch_q[gi] & ~lat_clr); // [RQ4] [RQ5]
    end
  endgenerate

  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      state_q <= ctr_pkg::CTR_IDLE;
      cnt_q   <= `CTR_CNT_ZERO;
      sh_q    <= `CTR_BYTE_ZERO;
      ptr_q   <= `CTR_BYTE_ZERO;
      rw_q    <= 1'b0;
      oe_q    <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
      sh_q    <= sh_d;
      ptr_q   <= ptr_d;
      rw_q    <= rw_d;
      oe_q    <= oe_d;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      mask_q  <= `CTR_MASK_RST;
      latch_q <= `CTR_LATCH_RST;
      cond_q  <= `CTR_LATCH_RST;
      pend_q  <= 1'b0;
      srst_q  <= 1'b0;
    end else begin
      mask_q  <= mask_d;
      latch_q <= latch_d;
      cond_q  <= cond;
      pend_q  <= |(latch_q & ~mask_q[2:0]); // [RQ6]
      srst_q  <= key_hit; // [RQ1]
    end
  end

  assign o_sda           = 1'b0;
  assign o_sda_oe        = oe_q;
  assign o_event_pending = pend_q;
  assign o_soft_reset    = srst_q;

  // Checks
  sequence s_data_ack_rise;
    (state_q == ctr_pkg::CTR_WACK) && evt.scl_rise;
  endsequence

  sequence s_mask_write;
    s_data_ack_rise ##0 sel_mask;
  endsequence

  a_key_resets_mask: assert property ( // [RQ1]
    @(posedge i_clk_sys) disable iff (!i_reset_n)
    key_hit |=> (mask_q == `CTR_MASK_RST) && o_soft_reset)
    else $error("mask not restored by key");
  a_key_clears_latch: assert property ( // [RQ1]
    @(posedge i_clk_sys) disable iff (!i_reset_n)
    (key_hit && (ev_set == 3'h0)) |=> (latch_q == 3'h0))
    else $error("latch not cleared by key");
  a_software_reset_key_reads_zero: assert property ( // [RQ2]
    @(posedge i_clk_sys) disable iff (!i_reset_n)
    (rd_load && sel_srst) |=> (sh_q == `CTR_SOFTWARE_RESET_KEY_RST))
    else $error("reset register did not read zero");
  a_nonkey_no_reset: assert property ( // [RQ3]
    @(posedge i_clk_sys) disable iff (!i_reset_n)
    (wr_en && sel_srst && (sh_q != `CTR_RESET_KEY)) |=> $stable(mask_q) && !o_soft_reset)
    else $error("non-key write changed state");
  a_event_sets_latch: assert property ( // [RQ4]
    @(posedge i_clk_sys) disable iff (!i_reset_n)
    ev_set[`CTR_BIT_THERMAL] |=> latch_q[`CTR_BIT_THERMAL] [*1])
    else $error("thermal event not latched");
  a_read_clears_latch: assert property ( // [RQ5]
    @(posedge i_clk_sys) disable iff (!i_reset_n)
    (rd_load && sel_lat && (ev_set == 3'h0)) |=> (latch_q == 3'h0) && (sh_q[7:3] == 5'h00))
    else $error("latch read did not clear");
  a_mask_gates_pending: assert property ( // [RQ6]
    @(posedge i_clk_sys) disable iff (!i_reset_n)
    ((latch_q & ~mask_q[2:0]) == 3'h0) |=> !o_event_pending)
    else $error("masked event raised pending");
  a_live_status_bits: assert property ( // [RQ7]
    @(posedge i_clk_sys) disable iff (!i_reset_n)
    (rd_load && sel_live) |=> (sh_q == {5'h00, ~$past(i_thermal_shutdown),
                                        ~$past(i_sys_overvolt), ~$past(i_sys_undervolt)}))
    else $error("live status mismatch");
  a_ack_loads_mask: assert property ( // [RQ8]
    @(posedge i_clk_sys) disable iff (!i_reset_n)
    s_mask_write |=> (mask_q == $past(sh_q)))
    else $error("mask not loaded at ack");

endmodule // ctr_top_regs

// ==== bench/ctr_i2c_master_model.sv ====
// Serial bus master model that drives the clock line and pulls data low
`timescale 1ns/1ps

module ctr_i2c_master_model (
  // Clock
  input  wire logic i_clk_sys,
  // Bus lines
  input  wire logic i_sda,
  output logic      o_scl,
  output logic      o_sda_oe
);
  initial begin
    o_scl    = 1'b1;
    o_sda_oe = 1'b0;
  end

  task automatic w();
    repeat (4) @(posedge i_clk_sys);
    #1;
  endtask

  // Start or repeated start; data released before the clock rises
  task automatic bus_start();
    o_sda_oe = 1'b0;
    w();
    o_scl = 1'b1;
    w();
    o_sda_oe = 1'b1;
    w();
    o_scl = 1'b0;
    w();
  endtask

  task automatic bus_stop();
    o_sda_oe = 1'b1;
    w();
    o_scl = 1'b1;
    w();
    o_sda_oe = 1'b0;
    w();
  endtask

  task automatic bit_x(input logic b, output logic r);
    o_sda_oe = ~b;
    w();
    o_scl = 1'b1;
    w();
    r = i_sda;
    o_scl = 1'b0;
    w();
  endtask

  // Eight bits MSB first, then the acknowledge bit
  task automatic xb(input logic [7:0] d, input logic rel, output logic [7:0] q,
                    output logic a);
    for (int i = 7; i >= 0; i--) begin
      bit_x(d[i], q[i]);
    end
    bit_x(rel, a);
  endtask
endmodule // ctr_i2c_master_model

// ==== bench/tb.sv ====
// Self-checking bench for the top control register bank
`timescale 1ns/1ps

`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin miscompares++; \
  $display("ERROR %s exp %h got %h", n, e, g); end end

module tb;
  localparam logic [6:0] ADR  = 7'h55; // Arbitrary bus address
  localparam logic [7:0] CHIP = 8'h3c; // Arbitrary identification value
  logic clk = 1'b0;
  logic rst_n, scl, sda, m_oe, d_sda, d_oe, th, ov, uv, pend, srst;
  logic [7:0] q, q2, q3, junk;
  logic       ack;
  int   miscompares, check_count, pulses;
  // Rows: write enable, pointer, write data, expected read
  logic [24:0] rows [8] = '{{1'b0, 8'h00, 8'h00, CHIP}, {1'b0, 8'h03, 8'h00, 8'hff},
    {1'b1, 8'h03, 8'h5a, 8'h5a}, {1'b1, 8'h01, 8'h3c, 8'h00}, {1'b0, 8'h03, 8'h00, 8'h5a},
    {1'b1, 8'h04, 8'h00, 8'h07}, {1'b0, 8'h20, 8'h00, 8'h00}, {1'b1, 8'h03, 8'h00, 8'h00}};

  always #4 clk = ~clk;
  // Pull-up on the data wire
  assign sda = (m_oe || (d_oe && !d_sda)) ? 1'b0 : 1'b1;

  ctr_i2c_master_model m (.i_clk_sys(clk), .i_sda(sda), .o_scl(scl), .o_sda_oe(m_oe));

  ctr_top_regs #(.SLAVE_ADDR(ADR), .CHIP_ID(CHIP)) DUT (
    .i_clk_sys(clk), .i_reset_n(rst_n), .i_scl(scl), .i_sda(sda), .o_sda(d_sda),
    .o_sda_oe(d_oe), .i_thermal_shutdown(th), .i_sys_overvolt(ov),
    .i_sys_undervolt(uv), .o_event_pending(pend), .o_soft_reset(srst));

  // Sampled away from the launching edge; unknown counts as a pulse
  always @(negedge clk) begin
    if (srst !== 1'b0) pulses++;
  end

  task automatic wr(input logic [7:0] p, input logic [7:0] d);
    logic [7:0] x;
    logic       a;
    m.bus_start();
    m.xb({ADR, 1'b0}, 1'b1, x, a);
    m.xb(p, 1'b1, x, a);
    m.xb(d, 1'b1, x, a);
    `CHK("data ack", 1'b0, a)
    m.bus_stop();
  endtask

  task automatic rd(input logic [7:0] p, output logic [7:0] r);
    logic [7:0] x;
    logic       a;
    m.bus_start();
    m.xb({ADR, 1'b0}, 1'b1, x, a);
    m.xb(p, 1'b1, x, a);
    m.bus_start();
    m.xb({ADR, 1'b1}, 1'b1, x, a);
    m.xb(8'hff, 1'b1, r, a);
    m.bus_stop();
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  initial begin
    #600000;
    miscompares++;
    $display("ERROR watchdog exp done got hang");
    give_verdict();
  end

  initial begin
    rst_n = 1'b0;
    th = 1'b0;
    ov = 1'b0;
    uv = 1'b0;
    repeat (12) @(posedge clk);
    #1;
    `CHK("oe in reset", 1'b0, d_oe)
    `CHK("pending in reset", 1'b0, pend)
    rst_n = 1'b1;
    repeat (2) @(posedge clk);
    #1;
    $display("test reset done");
    foreach (rows[k]) begin
      if (rows[k][24]) wr(rows[k][23:16], rows[k][15:8]);
      rd(rows[k][23:16], q);
      `CHK("readback", rows[k][7:0], q)
    end
    `CHK("no soft reset", 0, pulses)
    $display("test table done");
    th = 1'b1;
    repeat (4) @(posedge clk);
    #1;
    `CHK("pending", 1'b1, pend)
    rd(8'h04, q);
    `CHK("live", 8'h03, q)
    rd(8'h02, q);
    `CHK("latch thermal", 8'h04, q)
    rd(8'h02, q);
    `CHK("latch cleared", 8'h00, q)
    `CHK("pending low", 1'b0, pend)
    ov = 1'b1;
    uv = 1'b1;
    rd(8'h02, q);
    `CHK("latch volt", 8'h03, q)
    wr(8'h03, 8'h07);
    th = 1'b0;
    repeat (2) @(posedge clk);
    #1;
    th = 1'b1;
    repeat (4) @(posedge clk);
    #1;
    `CHK("masked pending", 1'b0, pend)
    $display("test events done");
    wr(8'h01, 8'ha5);
    `CHK("soft reset", 1, pulses)
    rd(8'h02, q);
    `CHK("latch after key", 8'h00, q)
    rd(8'h03, q);
    `CHK("mask after key", 8'hff, q)
    rd(8'h01, q);
    `CHK("key reg", 8'h00, q)
    $display("test key done");
    // Wrong address: no acknowledge, nothing written
    m.bus_start();
    m.xb({ADR ^ 7'h01, 1'b0}, 1'b1, junk, ack);
    `CHK("wrong addr ack", 1'b1, ack)
    m.xb(8'h03, 1'b1, junk, ack);
    m.xb(8'h12, 1'b1, junk, ack);
    m.bus_stop();
    rd(8'h03, q);
    `CHK("wrong addr mask", 8'hff, q)
    // Sequential write across the latch into the mask
    m.bus_start();
    m.xb({ADR, 1'b0}, 1'b1, junk, ack);
    m.xb(8'h02, 1'b1, junk, ack);
    m.xb(8'hff, 1'b1, junk, ack);
    m.xb(8'h6b, 1'b1, junk, ack);
    `CHK("burst ack", 1'b0, ack)
    m.bus_stop();
    uv = 1'b0;
    // Sequential read with master acknowledge between bytes
    m.bus_start();
    m.xb({ADR, 1'b0}, 1'b1, junk, ack);
    m.xb(8'h02, 1'b1, junk, ack);
    m.bus_start();
    m.xb({ADR, 1'b1}, 1'b1, junk, ack);
    m.xb(8'hff, 1'b0, q, ack);
    m.xb(8'hff, 1'b0, q2, ack);
    m.xb(8'hff, 1'b1, q3, ack);
    m.bus_stop();
    `CHK("burst latch", 8'h00, q)
    `CHK("burst mask", 8'h6b, q2)
    `CHK("burst live", 8'h01, q3)
    $display("test bus done");
    // Reset in mid-run with thermal and overvoltage conditions already high
    rst_n = 1'b0;
    repeat (3) @(posedge clk);
    #1;
    `CHK("pending mid reset", 1'b0, pend)
    rst_n = 1'b1;
    repeat (2) @(posedge clk);
    #1;
    rd(8'h03, q);
    `CHK("mask after reset", 8'hff, q)
    rd(8'h02, q);
    `CHK("latch after reset", 8'h06, q)
    $display("test mid reset done");
    give_verdict();
  end
endmodule // tb
